// ### frame_acq_pkg.sv
// Types shared by the acquisition sequencer and its helpers.
// Assumes frame_acq_regs.svh supplies the numeric constants.
package frame_acq_pkg;

    typedef enum logic [2:0] {ST_IDLE, ST_READY, ST_EXPOSE, ST_REF, ST_IMG, ST_SEND} acq_state_t;

    typedef enum logic [1:0] {MODE_SINGLE, MODE_SERIES, MODE_ACCUM, MODE_RUN} acq_mode_t;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic        valid;
        logic [15:0] index;
        logic [15:0] exp_ms;
    } user_frame_t;

    typedef struct packed {
        logic        busy;
        logic        done;
        logic [15:0] ms_left;
        logic [31:0] pre;
    } timer_t;

endpackage

// ### frame_acq_regs.svh
// Register offsets, field positions, reset values and timing figures of the acquisition sequencer.
// Assumes byte addressing on an 8-bit register address.
`ifndef FRAME_ACQ_REGS_SVH
`define FRAME_ACQ_REGS_SVH

`define REG_CTRL        8'h00
`define REG_EXPOSURE    8'h04
`define REG_SERIES_LEN  8'h08
`define REG_FRAME_PER   8'h0c
`define REG_BINNING     8'h10
`define REG_STATUS      8'h14
`define REG_BIN_INFO    8'h18

`define CTRL_START      0
`define CTRL_ABORT      1
`define CTRL_HOST_TRIG  2
`define CTRL_MODE_LO    4
`define CTRL_MODE_HI    5
`define CTRL_INT_SRC    6
`define CTRL_LIVE       7

`define EXP_RST         16'h000a
`define LEN_RST         16'h0001
`define PER_RST         16'h0000
`define BIN_RST         2'h0

`define CLK_PERIOD_NS   25
`define NS_PER_MS       1000000
`define EXP_MAX_S       30
`define EXP_MAX_MS      (`EXP_MAX_S * 1000)

`endif

// ### frame_acq_seq.sv
// Acquisition sequencer: turns valid triggers into reference/image user frames per acquisition mode.
// Assumes a same-clock register master and a link transmitter that pulses tx_done per sent frame.
// Function
// R1 - Exposure setting is clamped to at most thirty seconds.
// R2 - Only triggers arriving while ready start a frame; others are dropped. An internal trigger is held in pace_ok until ready.
// R3 - Each user frame is a reference then image pair, sent as one unit.
// R4 - Single mode emits exactly one frame, from the first valid trigger.
// R5 - Single mode ignores all later triggers until the acquisition ends.
// R6 - Host programs series length first; one frame per valid trigger.
// R7 - Series mode counts triggers and ignores any beyond the programmed count.
// R8 - Accumulate mode sends individual frames; summing happens off the device.
// R9 - Run mode emits frames without count limit until aborted.
// R10 - Run mode sends frames back to back with no added gap.
// R11 - Live variant delivers the latest sensor frame with minimal buffering.
// R12 - Live host sends next trigger only after previous frame is sent.
// R13 - Live variant holds at most one user frame in memory.
// R14 - New exposure applies from next frame, never the one exposing.
// R15 - Exposure may be updated any number of times during acquisition.
// R16 - Internal source with no rate set triggers at fastest rate.
// R17 - A programmed lower rate spaces internal triggers accordingly.
// R18 - Host sets frame rate before start; running changes may be ignored.
// R19 - Square binning merges each pixel group into one super-pixel.
// R20 - Abort stops triggers, discards frame in progress, returns to idle.
`timescale 1ns/1ps
`include "frame_acq_regs.svh"
module frame_acq_seq
    import frame_acq_pkg::*;
#(
    parameter int CYC_PER_MS = `NS_PER_MS / `CLK_PERIOD_NS
) (
    input  wire logic                      clk_sys,
    input  wire logic                      rst_n,
    input  wire frame_acq_pkg::reg_req_t   reg_req,
    output logic [31:0]                    reg_rdata,
    input  wire logic                      ext_trig_pin,
    input  wire logic                      tx_done,
    output logic                           trig_ready,
    output logic                           sensor_expose,
    output frame_acq_pkg::user_frame_t     user_frame,
    output logic [3:0]                     bin_factor
);
    import frame_acq_pkg::*;

    typedef struct packed {
        acq_state_t  st;
        acq_mode_t   mode;
        logic        int_src;
        logic        live;
        logic [15:0] exp_pend;
        logic [15:0] exp_cur;
        logic [15:0] len;
        logic [15:0] per_set;
        logic [15:0] per_run;
        logic [1:0]  bin;
        logic [15:0] count;
        logic        pending;
        logic        pace_ok;
        logic        pace_load;
        logic        exp_load;
        logic        ext_prev;
        logic        ready;
        logic        expose;
        logic [3:0]  bin_f;
        user_frame_t frame;
        logic [31:0] rdata;
    } seq_t;

    seq_t s_q, s_d;
    logic rst_q;
    logic ext_s;
    logic exp_done;
    logic pace_done;
    logic ctrl_wr;
    logic trig;
    logic last_frame;

    // Release the async reset cleanly into the clock domain
    sync2 #(.W(1)) u_rst_sync (
        .clk   (clk_sys),
        .rst_n (rst_n),
        .d     (1'b1),
        .q     (rst_q)
    );

    sync2 #(.W(1)) u_trig_sync (
        .clk   (clk_sys),
        .rst_n (rst_q),
        .d     (ext_trig_pin),
        .q     (ext_s)
    );

    tick_timer #(.CYC_PER_MS(CYC_PER_MS)) u_exp_timer (
        .clk   (clk_sys),
        .rst_n (rst_q),
        .load  (s_q.exp_load),
        .ms    (s_q.exp_cur),
        .done  (exp_done)
    );

    tick_timer #(.CYC_PER_MS(CYC_PER_MS)) u_pace_timer (
        .clk   (clk_sys),
        .rst_n (rst_q),
        .load  (s_q.pace_load),
        .ms    (s_q.per_run),
        .done  (pace_done)
    );

    assign ctrl_wr = reg_req.wr && (reg_req.addr == `REG_CTRL);

    always_comb
    begin
        s_d           = s_q;
        s_d.frame     = '0;
        s_d.rdata     = '0;
        s_d.exp_load  = 1'b0;
        s_d.pace_load = 1'b0;
        s_d.ext_prev  = ext_s;
        trig          = 1'b0;
        last_frame    = 1'b0;

        if (reg_req.wr)
        begin
            case (reg_req.addr)
                `REG_EXPOSURE:
                begin
                    // Accepted at any time; only the next frame picks it up [R15]
                    if (reg_req.wdata > 32'(`EXP_MAX_MS))
                        s_d.exp_pend = 16'(`EXP_MAX_MS);      // [R1]
                    else
                        s_d.exp_pend = reg_req.wdata[15:0];
                end
                `REG_SERIES_LEN: s_d.len = reg_req.wdata[15:0]; // [R6]
                `REG_FRAME_PER:  s_d.per_set = reg_req.wdata[15:0];
                `REG_BINNING:    s_d.bin = reg_req.wdata[1:0];
                default: ;
            endcase
        end

        if (reg_req.rd)
        begin
            case (reg_req.addr)
                `REG_CTRL:       s_d.rdata = {24'h000000, s_q.live, s_q.int_src, s_q.mode, 4'h0};
                `REG_EXPOSURE:   s_d.rdata = {16'h0000, s_q.exp_pend};
                `REG_SERIES_LEN: s_d.rdata = {16'h0000, s_q.len};
                `REG_FRAME_PER:  s_d.rdata = {16'h0000, s_q.per_set};
                `REG_BINNING:    s_d.rdata = {30'h00000000, s_q.bin};
                `REG_STATUS:     s_d.rdata = {s_q.count, 11'h000, s_q.pending, s_q.ready, s_q.st};
                // Widened first: an 8x8 super-pixel does not fit in four bits
                `REG_BIN_INFO:   s_d.rdata = {24'h000000, 8'(s_q.bin_f) * 8'(s_q.bin_f)};
                default:         s_d.rdata = '0;
            endcase
        end

        // Super-pixel side is 1, 2, 4 or 8 sensor pixels [R19]
        s_d.bin_f = 4'h1 << s_q.bin;

        if (s_q.int_src)
        begin
            if (s_q.pace_load)
                s_d.pace_ok = 1'b0;
            else if (pace_done)
                s_d.pace_ok = 1'b1;                           // [R16] [R17]
            trig = s_q.pace_ok && !s_q.pace_load;
        end
        // Live relies on host pacing, so only the host trigger counts [R11] [R12]
        else if (s_q.live)
            trig = ctrl_wr && reg_req.wdata[`CTRL_HOST_TRIG];
        else
            trig = (ext_s && !s_q.ext_prev) || (ctrl_wr && reg_req.wdata[`CTRL_HOST_TRIG]);

        case (s_q.mode)
            MODE_SINGLE: last_frame = 1'b1;                   // [R4] [R5]
            MODE_SERIES,
            MODE_ACCUM:  last_frame = (s_q.count >= s_q.len); // [R7] [R8]
            default:     last_frame = 1'b0;                   // [R9]
        endcase

        case (s_q.st)
            ST_IDLE:
            begin
                if (ctrl_wr)
                begin
                    s_d.mode    = acq_mode_t'(reg_req.wdata[`CTRL_MODE_HI:`CTRL_MODE_LO]);
                    s_d.int_src = reg_req.wdata[`CTRL_INT_SRC] && !reg_req.wdata[`CTRL_LIVE];
                    s_d.live    = reg_req.wdata[`CTRL_LIVE];
                    if (reg_req.wdata[`CTRL_START] && !reg_req.wdata[`CTRL_ABORT])
                    begin
                        s_d.st      = ST_READY;
                        s_d.count   = '0;
                        s_d.per_run = s_q.per_set;            // [R18]
                        s_d.pace_ok = 1'b1;
                        if (reg_req.wdata[`CTRL_LIVE])
                            s_d.mode = MODE_RUN;
                    end
                end
            end
            ST_READY:
            begin
                // External and host triggers in any other state fall through unseen; pace_ok holds an internal one [R2]
                if (trig)
                begin
                    s_d.st        = ST_EXPOSE;
                    s_d.exp_cur   = s_q.exp_pend;             // [R14]
                    s_d.exp_load  = 1'b1;
                    s_d.pace_load = s_q.int_src;              // [R17]
                    s_d.count     = s_q.count + 16'h0001;
                end
            end
            ST_EXPOSE:
                if (exp_done)
                    s_d.st = ST_REF;
            ST_REF:
                s_d.st = ST_IMG;                              // [R3]
            ST_IMG:
            begin
                s_d.st           = ST_SEND;
                s_d.pending      = 1'b1;                      // [R13]
                s_d.frame.valid  = 1'b1;                      // [R3]
                s_d.frame.index  = s_q.count;
                s_d.frame.exp_ms = s_q.exp_cur;
            end
            ST_SEND:
            begin
                if (tx_done)
                begin
                    s_d.pending = 1'b0;
                    // Straight back to ready: no deliberate gap between frames [R10]
                    s_d.st = last_frame ? ST_IDLE : ST_READY;
                end
            end
            default: s_d.st = ST_IDLE;
        endcase

        // Abort beats everything, frame in flight is dropped [R20]
        if (ctrl_wr && reg_req.wdata[`CTRL_ABORT])
        begin
            s_d.st       = ST_IDLE;
            s_d.pending  = 1'b0;
            s_d.frame    = '0;
            s_d.exp_load = 1'b0;
            // A trigger landing with the abort must not start a frame
            s_d.exp_cur   = s_q.exp_cur;
            s_d.pace_load = 1'b0;
        end

        s_d.ready  = (s_d.st == ST_READY);
        s_d.expose = (s_d.st == ST_EXPOSE);
    end

    always_ff @(posedge clk_sys or negedge rst_q)
    begin
        if (!rst_q)
        begin
            s_q          <= '0;
            s_q.exp_pend <= `EXP_RST;
            s_q.len      <= `LEN_RST;
            s_q.per_set  <= `PER_RST;
            s_q.bin      <= `BIN_RST;
            s_q.bin_f    <= 4'h1;
        end
        else
            s_q <= s_d;
    end

    assign reg_rdata     = s_q.rdata;
    assign trig_ready    = s_q.ready;
    assign sensor_expose = s_q.expose;
    assign user_frame    = s_q.frame;
    assign bin_factor    = s_q.bin_f;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_q);

    exp_clamp_a: assert property (s_q.exp_pend <= 16'(`EXP_MAX_MS)) // [R1]
        else $error("exposure above limit");
    trig_ready_a: assert property (s_q.exp_load |-> $past(s_q.st) == ST_READY) // [R2]
        else $error("frame started outside ready");
    pair_order_a: assert property (disable iff (!rst_q || (ctrl_wr && reg_req.wdata[`CTRL_ABORT])) // [R3]
        s_q.st == ST_REF |=> s_q.st == ST_IMG ##1 s_q.frame.valid)
        else $error("reference not followed by image");
    single_one_a: assert property (s_q.frame.valid && s_q.mode == MODE_SINGLE |-> s_q.frame.index == 16'h0001) // [R4]
        else $error("single mode emitted extra frame");
    single_end_a: assert property (s_q.st == ST_SEND && tx_done && s_q.mode == MODE_SINGLE |=> s_q.st == ST_IDLE) // [R5]
        else $error("single mode did not end");
    series_cap_a: assert property (s_q.frame.valid && s_q.mode == MODE_SERIES |-> s_q.frame.index <= s_q.len) // [R7]
        else $error("series exceeded count");
    run_back_a: assert property (s_q.st == ST_SEND && tx_done && s_q.mode == MODE_RUN && !ctrl_wr |=> s_q.ready) // [R10]
        else $error("run mode not back to back");
    live_one_a: assert property (s_q.live && s_q.frame.valid |-> !$past(s_q.pending)) // [R13]
        else $error("second frame in memory");
    exp_next_a: assert property ($changed(s_q.exp_cur) |-> s_q.exp_load) // [R14]
        else $error("exposure changed mid frame");
    abort_idle_a: assert property (ctrl_wr && reg_req.wdata[`CTRL_ABORT] |=> s_q.st == ST_IDLE && !s_q.pending) // [R20]
        else $error("abort did not return idle");

    single_done_c: cover property (s_q.mode == MODE_SINGLE && s_q.frame.valid);
    series_done_c: cover property (s_q.mode == MODE_SERIES && s_q.st == ST_SEND ##1 s_q.st == ST_IDLE);
    live_frame_c: cover property (s_q.live && s_q.frame.valid);
    abort_run_c: cover property (s_q.st == ST_EXPOSE ##1 s_q.st == ST_IDLE);
endmodule // frame_acq_seq

// ### frame_acquisition_sequencer_tb.sv
// Bench for frame_acq_seq: register bus, all modes, trigger sources.
// Assumes host_link_model as link partner and CYC_PER_MS of 4.
`timescale 1ns/1ps
`include "frame_acq_regs.svh"
module frame_acquisition_sequencer_tb;
    import frame_acq_pkg::*;
    localparam int CYC = 4;
    logic        clk_sys;
    logic        rst_n;
    reg_req_t    reg_req;
    logic [31:0] reg_rdata;
    logic        ext_trig_pin;
    logic        tx_done;
    logic        trig_ready;
    logic        sensor_expose;
    user_frame_t user_frame;
    logic [3:0]  bin_factor;
    logic [2:0]  stall;
    logic [63:0] rq[$];
    logic [31:0] fq[$];
    logic [31:0] rnd = 32'h88c9;
    logic [15:0] exp_cur = 16'h000a;
    logic        rd_d = 1'b0;
    logic        exp_d = 1'b0;
    int          num_errors = 0;
    int          compares = 0;
    int          cyc = 0;
    int          last_rise = 0;
    int          gap = 0;
    int          frames_seen = 0;
    logic [7:0]  ra[8] = '{`REG_CTRL, `REG_EXPOSURE, `REG_SERIES_LEN, `REG_FRAME_PER, `REG_BINNING,
                           `REG_STATUS, `REG_BIN_INFO, 8'h1c};
    logic [31:0] rv[8] = '{32'h0, {16'h0, `EXP_RST}, {16'h0, `LEN_RST}, {16'h0, `PER_RST}, 32'h0, 32'h0,
                           32'h1, 32'h0};

    frame_acq_seq #(.CYC_PER_MS(CYC)) DUT (.clk_sys(clk_sys), .rst_n(rst_n), .reg_req(reg_req),
        .reg_rdata(reg_rdata), .ext_trig_pin(ext_trig_pin), .tx_done(tx_done), .trig_ready(trig_ready),
        .sensor_expose(sensor_expose), .user_frame(user_frame), .bin_factor(bin_factor));
    host_link_model link (.clk(clk_sys), .frame_valid(user_frame.valid), .stall(stall), .tx_done(tx_done));

    initial
    begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic report(input logic [31:0] got, input logic [31:0] x);
        num_errors++;
        $display("[ERR] t=%0t got=%h exp=%h", $time, got, x);
    endtask

    task automatic cmp_read(input logic [31:0] got, input logic [63:0] x);
        compares++;
        if ((got & x[63:32]) !== x[31:0])
            report(got, x[31:0]);
    endtask

    task automatic cmp_frame(input user_frame_t got, input logic [31:0] x);
        compares++;
        if ({got.index, got.exp_ms} !== x)
            report({got.index, got.exp_ms}, x);
    endtask

    task automatic cmp_flag(input logic got);
        compares++;
        if (got !== 1'b1)
            report({31'h0, got}, 32'h1);
    endtask

    task automatic final_report();
        if (num_errors == 0 && compares > 0)
        begin
            $display("SIMULATION PASSED");
        end
        else
        begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Strobe one cycle, then idle one cycle so no edge is assigned twice
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_req <= '{w, ~w, a, d};
        @(posedge clk_sys);
        reg_req <= '0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m);
        rq.push_back({m, x});
        bus(1'b0, a, 32'h0);
    endtask

    // act: b0 start, b1 abort, b2 host trigger
    task automatic ctrl(input logic [1:0] m, input logic lv, input logic src, input logic [2:0] act);
        bus(1'b1, `REG_CTRL, {24'h0, lv, src, m, 1'b0, act});
    endtask

    // s: 0 ready, 1 tx_done, 2 exposing, 3 frame count reached
    task automatic wait_hi(input int s, input int tgt);
        int n;
        n = 0;
        do
        begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        while (!((s == 0 && trig_ready === 1'b1) || (s == 1 && tx_done === 1'b1) ||
                 (s == 2 && sensor_expose === 1'b1) || (s == 3 && frames_seen >= tgt)) && n < 3000);
        cmp_flag(n < 3000);
    endtask

    task automatic pin_pulse();
        @(posedge clk_sys);
        ext_trig_pin <= 1'b1;
        repeat (4) @(posedge clk_sys);
        ext_trig_pin <= 1'b0;
    endtask

    task automatic host_trig(input logic [1:0] m, input logic lv, input int i);
        wait_hi(0, 0);
        fq.push_back({16'(i), exp_cur});
        stall = rnd[2:0];
        ctrl(m, lv, 1'b0, 3'h4);
        wait_hi(2, 0);
        cmp_flag(trig_ready === 1'b0);
        ctrl(m, lv, 1'b0, 3'h4);
        rnd = lfsr(rnd);
        exp_cur = {14'h0, rnd[1:0]} + 16'h1;
        bus(1'b1, `REG_EXPOSURE, {16'h0, exp_cur});
        wait_hi(1, 0);
    endtask

    task automatic acq(input logic [1:0] m, input logic lv, input int n, input int extra, input logic stop);
        ctrl(m, lv, 1'b0, 3'h1);
        for (int i = 1; i <= n; i++)
            host_trig(m, lv, i);
        repeat (extra)
        begin
            ctrl(m, lv, 1'b0, 3'h4);
            repeat (20) @(posedge clk_sys);
        end
        if (stop)
            ctrl(m, lv, 1'b0, 3'h2);
        rd(`REG_STATUS, 32'h0, 32'h1f);
    endtask

    always @(posedge clk_sys)
    begin
        cyc <= cyc + 1;
        rd_d <= reg_req.rd;
        exp_d <= sensor_expose;
        if (rd_d)
        begin
            if (rq.size() == 0)
                cmp_flag(1'b0);
            else
                cmp_read(reg_rdata, rq.pop_front());
        end
        if (user_frame.valid === 1'b1)
        begin
            frames_seen <= frames_seen + 1;
            if (fq.size() == 0)
                cmp_flag(1'b0);
            else
                cmp_frame(user_frame, fq.pop_front());
        end
        if (sensor_expose === 1'b1 && exp_d === 1'b0)
        begin
            gap <= cyc - last_rise;
            last_rise <= cyc;
        end
        // Longest path is well under this; a hang ends here
        if (cyc == 60000)
        begin
            num_errors++;
            final_report();
        end
    end

    initial
    begin
        rst_n = 1'b0;
        reg_req = '0;
        ext_trig_pin = 1'b0;
        stall = 3'h0;
        repeat (8) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        cmp_flag(bin_factor === 4'h1);
        for (int i = 0; i < 8; i++)
            rd(ra[i], rv[i], 32'hffffffff);
        for (int c = 0; c < 4; c++)
        begin
            bus(1'b1, `REG_BINNING, 32'(c));
            rd(`REG_BIN_INFO, 32'h1 << (2 * c), 32'hffffffff);
            cmp_flag(bin_factor === 4'(1 << c));
        end
        bus(1'b1, `REG_EXPOSURE, 32'h9c40);
        rd(`REG_EXPOSURE, `EXP_MAX_MS, 32'hffffffff);
        bus(1'b1, `REG_EXPOSURE, 32'h7531);
        rd(`REG_EXPOSURE, `EXP_MAX_MS, 32'hffffffff);
        exp_cur = 16'h0002;
        bus(1'b1, `REG_EXPOSURE, {16'h0, exp_cur});
        acq(2'h0, 1'b0, 1, 2, 1'b0);
        bus(1'b1, `REG_SERIES_LEN, 32'h3);
        acq(2'h1, 1'b0, 3, 1, 1'b0);
        bus(1'b1, `REG_SERIES_LEN, 32'h2);
        acq(2'h2, 1'b0, 2, 1, 1'b0);
        acq(2'h3, 1'b0, 4, 0, 1'b1);
        acq(2'h0, 1'b1, 2, 0, 1'b1);
        pin_pulse();
        bus(1'b1, `REG_SERIES_LEN, 32'h1);
        ctrl(2'h1, 1'b0, 1'b0, 3'h1);
        wait_hi(0, 0);
        fq.push_back({16'h1, exp_cur});
        pin_pulse();
        wait_hi(1, 0);
        rd(`REG_STATUS, 32'h0, 32'h7);
        ctrl(2'h3, 1'b0, 1'b0, 3'h1);
        wait_hi(0, 0);
        ctrl(2'h3, 1'b0, 1'b0, 3'h4);
        wait_hi(2, 0);
        ctrl(2'h3, 1'b0, 1'b0, 3'h2);
        repeat (40) @(posedge clk_sys);
        rd(`REG_STATUS, 32'h0, 32'h1f);
        // Zero exposure and a slow link keep the free-running gap below the paced one
        bus(1'b1, `REG_EXPOSURE, 32'h0);
        exp_cur = 16'h0;
        stall = 3'h4;
        for (int p = 0; p < 2; p++)
        begin
            bus(1'b1, `REG_FRAME_PER, 32'(5 * p));
            for (int i = 1; i <= 3; i++)
                fq.push_back({16'(i), 16'h0});
            ctrl(2'h3, 1'b0, 1'b1, 3'h1);
            wait_hi(3, frames_seen + 3);
            ctrl(2'h3, 1'b0, 1'b1, 3'h2);
            cmp_flag((gap >= 5 * CYC) == (p == 1));
        end
        repeat (20) @(posedge clk_sys);
        cmp_flag(fq.size() == 0 && rq.size() == 0);
        final_report();
    end
endmodule // frame_acquisition_sequencer_tb

// ### host_link_model.sv
// Host link model: acknowledges each user frame after a stall.
// Assumes the sequencer clock; the bench sets the stall.
`timescale 1ns/1ps
module host_link_model (
    input  wire logic       clk,
    input  wire logic       frame_valid,
    input  wire logic [2:0] stall,
    output logic            tx_done
);
    initial tx_done = 1'b0;
    // One frame in flight; a slow link only delays tx_done
    always @(posedge clk)
    begin
        if (frame_valid === 1'b1)
        begin
            repeat (stall) @(posedge clk);
            tx_done <= 1'b1;
            @(posedge clk);
            tx_done <= 1'b0;
        end
    end
endmodule // host_link_model

// ### sync2.sv
// Two-flop synchroniser for levels entering the clk_sys domain.
// Assumes the input is a level held far longer than one clock period.
`timescale 1ns/1ps
module sync2 #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [1:0][W-1:0] s_q;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            s_q <= '0;
        else
            s_q <= {s_q[0], d};
    end

    assign q = s_q[1];
endmodule // sync2

// ### tick_timer.sv
// Millisecond down-timer; done pulses once when a loaded interval has run out.
// Assumes a synchronous reset already released through the reset synchroniser.
`timescale 1ns/1ps
`include "frame_acq_regs.svh"
module tick_timer
    import frame_acq_pkg::*;
#(
    parameter int CYC_PER_MS = `NS_PER_MS / `CLK_PERIOD_NS
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        load,
    input  wire logic [15:0] ms,
    output logic             done
);
    timer_t s_q, s_d;

    always_comb
    begin
        s_d      = s_q;
        s_d.done = 1'b0;
        if (load)
        begin
            s_d.busy    = 1'b1;
            s_d.ms_left = ms;
            s_d.pre     = '0;
        end
        else if (s_q.busy)
        begin
            if (s_q.ms_left == 16'h0000)
            begin
                s_d.busy = 1'b0;
                s_d.done = 1'b1;
            end
            else if (s_q.pre == 32'(CYC_PER_MS - 1))
            begin
                s_d.pre     = '0;
                s_d.ms_left = s_q.ms_left - 16'h0001;
            end
            else
                s_d.pre = s_q.pre + 32'h0000_0001;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign done = s_q.done;
endmodule // tick_timer
